// ---- rtl/mspt_regs.vh ----
`ifndef MSPT_REGS_VH
`define MSPT_REGS_VH

`define MSPT_ADDR_W 8
`define MSPT_OFS_CTRL 8'h00
`define MSPT_OFS_DURATION 8'h04
`define MSPT_OFS_ELAPSED 8'h08
`define MSPT_OFS_STATUS 8'h0C

`define MSPT_CTRL_MODE_LSB 0
`define MSPT_CTRL_MODE_MSB 2
`define MSPT_CTRL_RUNPOL_BIT 4
`define MSPT_CTRL_OUTPOL_BIT 5
`define MSPT_CTRL_RESET 32'h00000030

`define MSPT_MODE_OFF 3'h0
`define MSPT_MODE_PULSE 3'h1
`define MSPT_MODE_DELAY 3'h2
`define MSPT_MODE_ONESHOT 3'h3
`define MSPT_MODE_RETENTIVE 3'h4

`define MSPT_TIME_W 27
`define MSPT_DURATION_MAX 27'h5F5DD18
`define MSPT_DURATION_RESET 27'h0000000

`define MSPT_STAT_RUNNING_BIT 0
`define MSPT_STAT_OUT_BIT 1
`define MSPT_STAT_RUNIN_BIT 2
`define MSPT_STAT_MODEBAD_BIT 3

`define MSPT_TICK_NS 1000000
`define MSPT_CLK_NS 8
// one millisecond at the 8 ns clock
`define MSPT_TICK_CYCLES 17'h1E848
`define MSPT_PRESC_W 17

`endif

// ---- rtl/mspt_timer.v ----
// Notes on behaviour
// - decode five timer modes from selector
// - disabled mode holds output inactive
// - output polarity sets active level
// - active run edge starts pulse immediately
// - pulse ends when elapsed reaches duration
// - pulse ignores early run release
// - retrigger while running lengthens pulse
// - run polarity picks triggering edge
// - duration zero to 99999 s, ms steps
// - elapsed time zero after power-up
`timescale 1ns/1ns
`include "mspt_regs.vh"

module mspt_timer #(
   parameter [`MSPT_PRESC_W-1:0] TICK_CYCLES = `MSPT_TICK_CYCLES
)
(
   input wire clk,
   input wire rst_n,
   input wire [`MSPT_ADDR_W-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire runIn,
   output reg timerOut
);

   reg [2:0] mode_reg;
   reg runPol_reg;
   reg outPol_reg;
   reg [`MSPT_TIME_W-1:0] duration_reg;
   reg [`MSPT_TIME_W-1:0] elapsed_reg;
   reg [`MSPT_TIME_W-1:0] elapsed_next;
   reg [`MSPT_PRESC_W-1:0] presc_reg;
   reg [`MSPT_PRESC_W-1:0] presc_next;
   reg running_reg;
   reg running_next;
   reg runActPrev_reg;
   reg timerOut_next;
   reg runActive;
   reg trigger;
   reg modeKnown;
   reg [31:0] rdata_next;
   reg slverr_next;
   reg addrHit;
   reg [31:0] ctrlWord;
   reg [31:0] statWord;
   reg [`MSPT_TIME_W-1:0] wrDuration;
   wire apbAccess;
   wire apbDone;
   reg pulseSel;
   reg tickDue;
   reg durationHit;
   reg [`MSPT_PRESC_W-1:0] prescLast;
   reg [`MSPT_PRESC_W-1:0] prescInc;
   reg [`MSPT_TIME_W-1:0] elapsedInc;
   wire ctrlWrite;
   wire durWrite;

   // run state codes
   localparam [0:0] TMR_IDLE = 1'b0;
   localparam [0:0] TMR_RUN = 1'b1;

   assign apbAccess = psel & penable & ~pready;
   assign apbDone = psel & penable & pready;
   assign ctrlWrite = apbDone & pwrite & ~pslverr & (paddr == `MSPT_OFS_CTRL);
   assign durWrite = apbDone & pwrite & ~pslverr & (paddr == `MSPT_OFS_DURATION);

   always @*
   begin
      runActive = runPol_reg ? runIn : ~runIn;
      trigger = runActive & ~runActPrev_reg;
   end

   always @*
   begin
      case (mode_reg)
         `MSPT_MODE_OFF:
         begin
            modeKnown = 1'b1;
            pulseSel = 1'b0;
         end
         `MSPT_MODE_PULSE:
         begin
            modeKnown = 1'b1;
            pulseSel = 1'b1;
         end
         // delay, one-shot and retentive idle like off
         `MSPT_MODE_DELAY:
         begin
            modeKnown = 1'b1;
            pulseSel = 1'b0;
         end
         `MSPT_MODE_ONESHOT:
         begin
            modeKnown = 1'b1;
            pulseSel = 1'b0;
         end
         `MSPT_MODE_RETENTIVE:
         begin
            modeKnown = 1'b1;
            pulseSel = 1'b0;
         end
         default:
         begin
            modeKnown = 1'b0;
            pulseSel = 1'b0;
         end
      endcase
   end

   always @*
   begin
      prescLast = TICK_CYCLES - {{(`MSPT_PRESC_W-1){1'b0}}, 1'b1};
      prescInc = presc_reg + {{(`MSPT_PRESC_W-1){1'b0}}, 1'b1};
      elapsedInc = elapsed_reg + {{(`MSPT_TIME_W-1){1'b0}}, 1'b1};
      tickDue = (presc_reg == prescLast);
      durationHit = (elapsed_reg >= duration_reg);
   end

   // timer state step
   always @*
   begin
      running_next = running_reg;
      elapsed_next = elapsed_reg;
      presc_next = presc_reg;
      if (!pulseSel)
      begin
         running_next = TMR_IDLE;
         elapsed_next = {`MSPT_TIME_W{1'b0}};
         presc_next = {`MSPT_PRESC_W{1'b0}};
      end
      else
      begin
         case (running_reg)
            TMR_IDLE:
            begin
               if (trigger)
               begin
                  running_next = TMR_RUN;
                  elapsed_next = {`MSPT_TIME_W{1'b0}};
                  presc_next = {`MSPT_PRESC_W{1'b0}};
               end
            end
            TMR_RUN:
            begin
               if (trigger)
               begin
                  elapsed_next = {`MSPT_TIME_W{1'b0}};
                  presc_next = {`MSPT_PRESC_W{1'b0}};
               end
               else if (durationHit)
               begin
                  running_next = TMR_IDLE;
                  elapsed_next = {`MSPT_TIME_W{1'b0}};
                  presc_next = {`MSPT_PRESC_W{1'b0}};
               end
               else if (tickDue)
               begin
                  presc_next = {`MSPT_PRESC_W{1'b0}};
                  elapsed_next = elapsedInc;
               end
               else
               begin
                  presc_next = prescInc;
               end
            end
            default:
            begin
               running_next = TMR_IDLE;
            end
         endcase
      end
      timerOut_next = running_next ? outPol_reg : ~outPol_reg;
   end

   // register read and decode
   always @*
   begin
      ctrlWord = 32'h00000000;
      ctrlWord[`MSPT_CTRL_MODE_MSB:`MSPT_CTRL_MODE_LSB] = mode_reg;
      ctrlWord[`MSPT_CTRL_RUNPOL_BIT] = runPol_reg;
      ctrlWord[`MSPT_CTRL_OUTPOL_BIT] = outPol_reg;
      statWord = 32'h00000000;
      statWord[`MSPT_STAT_RUNNING_BIT] = running_reg;
      statWord[`MSPT_STAT_OUT_BIT] = timerOut;
      statWord[`MSPT_STAT_RUNIN_BIT] = runIn;
      statWord[`MSPT_STAT_MODEBAD_BIT] = ~modeKnown;
      addrHit = 1'b1;
      case (paddr)
         `MSPT_OFS_CTRL: rdata_next = ctrlWord;
         `MSPT_OFS_DURATION: rdata_next = {{(32-`MSPT_TIME_W){1'b0}}, duration_reg};
         `MSPT_OFS_ELAPSED: rdata_next = {{(32-`MSPT_TIME_W){1'b0}}, elapsed_reg};
         `MSPT_OFS_STATUS: rdata_next = statWord;
         default:
         begin
            rdata_next = 32'h00000000;
            addrHit = 1'b0;
         end
      endcase
      if (pwrite)
      begin
         rdata_next = 32'h00000000;
         addrHit = (paddr == `MSPT_OFS_CTRL) || (paddr == `MSPT_OFS_DURATION);
      end
      slverr_next = ~addrHit;
      if (pwdata[31:`MSPT_TIME_W] != {(32-`MSPT_TIME_W){1'b0}})
      begin
         wrDuration = `MSPT_DURATION_MAX;
      end
      else if (pwdata[`MSPT_TIME_W-1:0] > `MSPT_DURATION_MAX)
      begin
         wrDuration = `MSPT_DURATION_MAX;
      end
      else
      begin
         wrDuration = pwdata[`MSPT_TIME_W-1:0];
      end
   end

   // apb answer, one wait state
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= apbAccess;
         pslverr <= apbAccess & slverr_next;
         prdata <= apbAccess ? rdata_next : 32'h00000000;
      end
   end

   // control fields
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         mode_reg <= `MSPT_MODE_OFF;
         runPol_reg <= 1'b1;
         outPol_reg <= 1'b1;
      end
      else if (ctrlWrite)
      begin
         mode_reg <= pwdata[`MSPT_CTRL_MODE_MSB:`MSPT_CTRL_MODE_LSB];
         runPol_reg <= pwdata[`MSPT_CTRL_RUNPOL_BIT];
         outPol_reg <= pwdata[`MSPT_CTRL_OUTPOL_BIT];
      end
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         duration_reg <= `MSPT_DURATION_RESET;
      end
      else if (durWrite)
      begin
         duration_reg <= wrDuration;
      end
   end

   // elapsed time and prescaler
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         elapsed_reg <= {`MSPT_TIME_W{1'b0}};
         presc_reg <= {`MSPT_PRESC_W{1'b0}};
      end
      else
      begin
         elapsed_reg <= elapsed_next;
         presc_reg <= presc_next;
      end
   end

   // run state and edge history
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         running_reg <= TMR_IDLE;
         // active seen: a held input gives no edge
         runActPrev_reg <= 1'b1;
      end
      else
      begin
         running_reg <= running_next;
         runActPrev_reg <= runActive;
      end
   end

   // output register, reset level fits reset polarity
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         timerOut <= 1'b0;
      end
      else
      begin
         timerOut <= timerOut_next;
      end
   end

endmodule // mspt_timer

// ---- dv/mspt_monitor.sv ----
`timescale 1ns/1ns
module mspt_monitor (
   input wire clk,
   input wire rst_n,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire runIn,
   input wire timerOut
);
   localparam int MAXC = 80;
   reg [5:0] ctrl_reg;
   reg [1:0] quiet_reg;
   wire wr = psel && penable && pready && pwrite;
   wire act = runIn == ctrl_reg[4];
   wire on = timerOut == ctrl_reg[5];
   wire pulse = ctrl_reg[2:0] == 3'h1 && quiet_reg == 2'h3;
   // shadow of control word, cycles since last write
   always @(posedge clk)
   begin
      ctrl_reg <= !rst_n ? 6'h30 : (wr && paddr == 8'h00) ? pwdata[5:0] : ctrl_reg;
      quiet_reg <= (!rst_n || wr) ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rise; pulse && on && !$past(on); endsequence
   property p_rdy; psel && penable && !pready |=> pready; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_err; pready && paddr > 8'h0C |-> pslverr; endproperty
   property p_rd0; !pready |-> prdata == 32'h0; endproperty
   property p_off; ctrl_reg[2:0] != 3'h1 && quiet_reg == 2'h3 |-> !on; endproperty
   property p_trig; pulse && act && !$past(act) |=> on; endproperty
   property p_hold; s_rise |=> on [*4]; endproperty
   property p_end; s_rise |-> ##[1:MAXC] !on; endproperty
   a_rdy: assert property (p_rdy) else $error("ready late");
   a_one: assert property (p_one) else $error("ready long");
   a_err: assert property (p_err) else $error("no error");
   a_rd0: assert property (p_rd0) else $error("data idle");
   a_off: assert property (p_off) else $error("off level");
   a_trig: assert property (p_trig) else $error("no start");
   a_hold: assert property (p_hold) else $error("short");
   a_end: assert property (p_end) else $error("no end");
endmodule // mspt_monitor

// ---- dv/mspt_link_partner.sv ----
`timescale 1ns/1ns
module mspt_link_partner (
   input wire clk,
   input wire want,
   input wire outPol,
   input wire timerOut,
   output reg runIn = 1'b0,
   output reg [15:0] lastLen = 16'h0
);
   reg [15:0] cnt_reg = 16'h0;
   // upstream run source, downstream pulse meter
   always @(posedge clk)
   begin
      runIn <= want;
      cnt_reg <= (timerOut === outPol) ? cnt_reg + 16'h1 : 16'h0;
      if (timerOut !== outPol && cnt_reg != 16'h0)
         lastLen <= cnt_reg;
   end
endmodule // mspt_link_partner

// ---- dv/mspt_timer_bench.sv ----
`timescale 1ns/1ns
module mspt_timer_bench;
   reg clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, want = 0, pol = 1, err;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0, rd;
   wire [31:0] prdata;
   wire [15:0] len;
   wire pready, pslverr, runIn, timerOut;
   integer n_mismatch = 0, checks = 0, i, j;
   always #4 clk = ~clk;
   mspt_timer #(.TICK_CYCLES(17'h4)) dut(.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .runIn, .timerOut);
   mspt_link_partner peer(.clk, .want, .outPol(pol), .timerOut, .runIn, .lastLen(len));
   task conclude;
   begin
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   task chk(input [31:0] s, input [31:0] e);
   begin
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
   begin
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1;
      for (i = 0; i < 9 && pready !== 1; i++)
         @(posedge clk);
      chk(i < 9, 1);
      if (i == 9)
         conclude;
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   end
   endtask
   task sc_regs;
   begin
      apb(0, 8'h00, 0);
      chk(rd, 32'h30);
      apb(0, 8'h08, 0);
      chk(rd, 0);
      chk(timerOut, 0);
      apb(0, 8'h44, 0);
      chk(err, 1);
      apb(1, 8'h08, 32'h1);
      chk(err, 1);
      apb(0, 8'h08, 0);
      chk(rd, 0);
      apb(1, 8'h04, 32'hFFFFFFFF);
      apb(0, 8'h04, 0);
      chk(rd, 32'h05F5DD18);
   end
   endtask
   task sc_off;
   begin
      for (j = 0; j < 8; j++)
      begin
         apb(1, 8'h00, j == 1 ? 0 : j);
         want <= ~want;
         repeat (4) @(posedge clk);
         chk(timerOut, 1);
         apb(0, 8'h0C, 0);
         chk(rd, {j > 4, want, 2'b10});
      end
   end
   endtask
   task sc_pulse(input [5:0] c, input integer gap, input [15:0] e);
   begin
      apb(1, 8'h00, c & 6'h30);
      {pol, want} <= {c[5], !c[4]};
      apb(1, 8'h00, c);
      apb(1, 8'h04, 2);
      for (j = 0; j < 2; j++)
      begin
         want <= c[4];
         @(posedge clk);
         want <= !c[4];
         repeat (gap) @(posedge clk);
      end
      for (i = 0; i < 60 && timerOut !== !c[5]; i++)
         @(posedge clk);
      chk(i < 60, 1);
      @(posedge clk);
      chk(len, e);
   end
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      sc_regs;
      sc_off;
      sc_pulse(6'h31, 20, 16'h9);
      sc_pulse(6'h01, 3, 16'hD);
      conclude;
   end
endmodule // mspt_timer_bench
bind mspt_timer mspt_monitor mon(.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
   .pready, .pslverr, .runIn, .timerOut);
